// File: dv/fill_flag_chk.sv
// Concurrent checks on the link between FIFO write side and its user.
// Assumes one clock hclk; instantiated beside the link interface in tb_top.
`timescale 1ns/1ns

module fill_flag_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fifo_rst,
    input wire logic wr_en,
    input wire logic full,
    input wire logic fill_high_flag,
    input wire fill_flag_pkg::count_t wr_count,
    input wire fill_flag_pkg::count_t fill_high_set_level_in,
    input wire fill_flag_pkg::count_t fill_high_release_level_in
);
    logic [1:0] settle_reg;
    logic live;

    // Edges since the FIFO left reset, saturating at three
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_reg <= 2'h0;
        end else if (fifo_rst) begin
            settle_reg <= 2'h0;
        end else if (settle_reg != 2'h3) begin
            settle_reg <= settle_reg + 2'h1;
        end
    end
    assign live = (settle_reg == 2'h3) && !fifo_rst;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Multi-step behaviours
    sequence rst_held_s;
        fifo_rst ##1 fifo_rst ##1 fifo_rst;
    endsequence
    // Release needs three lagged counts below the level
    sequence below_thrice_s;
        live && (wr_count < fill_high_release_level_in) ##1 (wr_count < fill_high_release_level_in)
            ##1 (wr_count < fill_high_release_level_in);
    endsequence

    rst_low_a: assert property (rst_held_s |-> !fill_high_flag && !full && wr_count == 5'h00)
        else $error("flag, full or count not clear in FIFO reset");
    set_high_a: assert property (live && wr_count >= fill_high_set_level_in |-> fill_high_flag)
        else $error("flag low at or above set level");
    rise_cause_a: assert property (live && $rose(fill_high_flag) |->
        wr_count >= fill_high_set_level_in && $past(wr_count) < fill_high_set_level_in)
        else $error("flag rose without crossing set level");
    fall_cause_a: assert property (live && $fell(fill_high_flag) |->
        wr_count < fill_high_release_level_in && $past(wr_count) < fill_high_release_level_in
        && $past(wr_count, 2) < fill_high_release_level_in)
        else $error("flag fell without three cycles below release level");
    release_a: assert property (below_thrice_s |-> !fill_high_flag)
        else $error("flag still high below release level");
    hold_a: assert property (live && fill_high_flag && wr_count >= fill_high_release_level_in |=> fill_high_flag)
        else $error("flag fell at or above release level");
    full_count_a: assert property (live |-> (wr_count == 5'h10) == $past(full))
        else $error("count does not trail full by one cycle");
    no_block_a: assert property (live && wr_en && !full |=> !fifo_rst |=> wr_count == $past(wr_count) + 5'h01)
        else $error("write below full was not taken");
    level_hold_a: assert property (live |-> $stable(fill_high_set_level_in)
        && $stable(fill_high_release_level_in))
        else $error("levels changed outside FIFO reset");

    flag_fall_c: cover property (live && $fell(fill_high_flag));
endmodule

// File: dv/tb_top.sv
// Bench for the high-fill flag device driven by its AHB-Lite controlled user.
// Assumes dual-level port mode on a memory variant plus a primitive twin on the same link inputs;
// bench plays AHB master and read side.
`timescale 1ns/1ns
`include "fill_flag_regs.svh"

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_en;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int fail_count = 0;
    int samples_checked = 0;

    fill_flag_if link_if();
    fill_high_user i_fill_high_user (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link_if));
    fill_high_dev #(.IMPL(fill_flag_pkg::IMPL_MEMORY), .MODE(fill_flag_pkg::MODE_DUAL_PORT)) i_fill_high_dev (
        .hclk(hclk), .hresetn(hresetn), .rd_en(rd_en), .link(link_if));
    // Primitive twin: asks for dual ports, must fall back to one constant level
    // level 12 lies within one primitive depth
    fill_flag_if link2_if();
    assign link2_if.fifo_rst = link_if.fifo_rst;
    assign link2_if.wr_en = link_if.wr_en;
    assign link2_if.fill_high_level_in = link_if.fill_high_level_in;
    assign link2_if.fill_high_set_level_in = link_if.fill_high_set_level_in;
    assign link2_if.fill_high_release_level_in = link_if.fill_high_release_level_in;
    fill_high_dev #(.IMPL(fill_flag_pkg::IMPL_PRIMITIVE), .MODE(fill_flag_pkg::MODE_DUAL_PORT)) i_fill_high_dev_prim (
        .hclk(hclk), .hresetn(hresetn), .rd_en(rd_en), .link(link2_if));
    fill_flag_chk i_fill_flag_chk (.hclk(hclk), .hresetn(hresetn), .fifo_rst(link_if.fifo_rst),
        .wr_en(link_if.wr_en), .full(link_if.full), .fill_high_flag(link_if.fill_high_flag),
        .wr_count(link_if.wr_count), .fill_high_set_level_in(link_if.fill_high_set_level_in),
        .fill_high_release_level_in(link_if.fill_high_release_level_in));
    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    // Counts, verdict and end of run
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One single AHB-Lite transfer, entered just after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= `FH_HTRANS_NONSEQ;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            fail_count++;
            stop_test();
        end
        htrans <= 2'h0;
        hwdata <= wdata;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        rdata = hrdata;
        if (hready !== 1'b1) begin
            fail_count++;
            stop_test();
        end
    endtask

    task automatic wr32(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] r;
        ahb(1'b1, addr, data, r);
    endtask

    // Reset values, field width and unmapped space
    task automatic reset_check();
        logic [31:0] offs [5] = '{`FH_OFF_CTRL, `FH_OFF_LEVEL, `FH_OFF_SET, `FH_OFF_RELEASE, `FH_OFF_STATUS};
        logic [31:0] exps [5] = '{32'h1, 32'hC, 32'hC, 32'h8, 32'h0};
        logic [31:0] r;
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, offs[i], 32'h0, r);
            `CHK(r, exps[i])
        end
        wr32(32'h0000_0020, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h0000_0020, 32'h0, r);
        `CHK(r, 32'h0)
        wr32(`FH_OFF_LEVEL, 32'hFFFF_FFE3);
        ahb(1'b0, `FH_OFF_LEVEL, 32'h0, r);
        `CHK(r, 32'h3)
        `CHK(hresp, 1'b0)
    endtask

    // Levels set in reset, fill to full past the set level, stray level writes
    task automatic fill_check(input logic [31:0] set, input logic [31:0] rel);
        logic [31:0] st;
        wr32(`FH_OFF_CTRL, 32'h1);
        wr32(`FH_OFF_SET, set);
        wr32(`FH_OFF_RELEASE, rel);
        ahb(1'b0, `FH_OFF_STATUS, 32'h0, st);
        `CHK(st, 32'h0)
        wr32(`FH_OFF_CTRL, 32'h2);
        wr32(`FH_OFF_SET, 32'h1F);
        wr32(`FH_OFF_RELEASE, 32'h1F);
        repeat (40) @(posedge hclk);
        wr32(`FH_OFF_CTRL, 32'h0);
        ahb(1'b0, `FH_OFF_STATUS, 32'h0, st);
        `CHK(st[1], 1'b1)
        `CHK(st[0], 1'b1)
        `CHK(st[12:8], 5'h10)
        `CHK(link2_if.fill_high_flag, 1'b1)
    endtask

    // Drain one entry at a time; flag keeps state until below release level
    task automatic drain_check(input int rel);
        logic [31:0] st;
        logic exp_flag;
        logic exp_prim;
        exp_flag = 1'b1;
        exp_prim = 1'b1;
        for (int c = 15; c >= 0; c--) begin
            rd_en <= 1'b1;
            @(posedge hclk);
            rd_en <= 1'b0;
            repeat (2) @(posedge hclk);
            ahb(1'b0, `FH_OFF_STATUS, 32'h0, st);
            if (c < rel) exp_flag = 1'b0;
            if (c < `FH_LEVEL_RESET - 1) exp_prim = 1'b0;
            `CHK(st[12:8], c[4:0])
            `CHK(st[0], exp_flag)
            `CHK(link2_if.fill_high_flag, exp_prim)
            `CHK(st[1], 1'b0)
        end
    endtask

    // Clock of 10 ns period
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_en = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_check();
        fill_check(32'hA, 32'h7);
        drain_check(7);
        fill_check(32'h10, 32'h1);
        drain_check(1);
        fill_check(32'hC, 32'hB);
        drain_check(11);
        stop_test();
    end
endmodule

// File: verilog/fill_flag_if.sv
// Link between the FIFO write side with high-fill flag and its user.
// Assumes both ends run on the same hclk.
`timescale 1ns/1ns

interface fill_flag_if;
    logic fifo_rst;
    logic wr_en;
    logic full;
    logic fill_high_flag;
    fill_flag_pkg::count_t wr_count;
    fill_flag_pkg::count_t fill_high_level_in;
    fill_flag_pkg::count_t fill_high_set_level_in;
    fill_flag_pkg::count_t fill_high_release_level_in;

    modport dev (
        input fifo_rst,
        input wr_en,
        output full,
        output fill_high_flag,
        output wr_count,
        input fill_high_level_in,
        input fill_high_set_level_in,
        input fill_high_release_level_in
    );
    modport user (
        output fifo_rst,
        output wr_en,
        input full,
        input fill_high_flag,
        input wr_count,
        output fill_high_level_in,
        output fill_high_set_level_in,
        output fill_high_release_level_in
    );
endinterface

// File: verilog/fill_flag_pkg.sv
// Types shared by the high-fill flag device and its controller.
// Assumes fill_flag_regs.svh is on the include path.
`include "fill_flag_regs.svh"

package fill_flag_pkg;
    typedef logic [`FH_CNT_W-1:0] count_t;
    typedef enum logic [1:0] {
        MODE_SINGLE_CONST = 2'h0,
        MODE_SINGLE_PORT = 2'h1,
        MODE_DUAL_PORT = 2'h3,
        MODE_DUAL_CONST = 2'h2
    } level_mode_t;
    typedef enum logic {
        IMPL_MEMORY = 1'h0,
        IMPL_PRIMITIVE = 1'h1
    } impl_t;
    // Path LOW -> HIGH -> DROP -> LOW; one bit per step except DROP -> LOW
    typedef enum logic [1:0] {
        FS_LOW = 2'h0,
        FS_HIGH = 2'h1,
        FS_DROP = 2'h3
    } flag_state_t;
    typedef struct packed {
        count_t count;
        count_t count_out;
        logic full;
        logic flag;
        flag_state_t fstate;
        logic [`FH_RELEASE_LAG-1:0] lag;
        count_t set_lvl;
        count_t rel_lvl;
    } dev_state_t;
    typedef struct packed {
        logic [1:0] ctrl;
        count_t level;
        count_t set_lvl;
        count_t rel_lvl;
        count_t level_out;
        count_t set_out;
        count_t rel_out;
        logic wr_en;
        logic pend;
        logic pend_write;
        logic [31:0] pend_addr;
        logic hreadyout;
        logic [31:0] hrdata;
    } user_state_t;
endpackage

// File: verilog/fill_flag_regs.svh
// Constants for the high-fill flag block and its write-side controller.
// Assumes one clock hclk at 100 MHz and AHB-Lite on the controller.
// Operation
// - Flag high when count reaches set level
// - Flag never blocks writes; only full does
// - Dual mode releases below release level
// - Flag rises one edge after causing write
// - Release may take longer than assertion
// - Primitive single mode releases below level-1
// - Memory single mode releases below level
// - Single level input changes only in reset
// - Set/release inputs change only in reset
// - Constant levels fixed by elaboration parameters
// - Dual levels only on memory variants
// - Set level must exceed release level
// - Primitive variants: one constant level only
// - Flag and count lag write one cycle
// - Primitive level within one primitive depth
// - Out-of-range levels give unpredictable behaviour
`ifndef FILL_FLAG_REGS_SVH
`define FILL_FLAG_REGS_SVH

`define FH_DEPTH 5'h10
`define FH_CNT_W 5
`define FH_RELEASE_LAG 1
`define FH_OFF_CTRL 32'h0000_0000
`define FH_OFF_LEVEL 32'h0000_0004
`define FH_OFF_SET 32'h0000_0008
`define FH_OFF_RELEASE 32'h0000_000C
`define FH_OFF_STATUS 32'h0000_0010
`define FH_CTRL_RST_BIT 0
`define FH_CTRL_PUSH_BIT 1
`define FH_STAT_FLAG_BIT 0
`define FH_STAT_FULL_BIT 1
`define FH_STAT_CNT_LSB 8
`define FH_CTRL_RESET 2'h1
`define FH_LEVEL_RESET 5'h0C
`define FH_SET_RESET 5'h0C
`define FH_RELEASE_RESET 5'h08
`define FH_HTRANS_NONSEQ 2'h2

`endif

// File: verilog/fill_high_dev.sv
// FIFO write-side occupancy with programmable high-fill flag.
// Assumes synchronous inputs on hclk; rd_en drains from the read side.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`include "fill_flag_regs.svh"

module fill_high_dev #(
    parameter fill_flag_pkg::impl_t IMPL = fill_flag_pkg::IMPL_MEMORY,
    parameter fill_flag_pkg::level_mode_t MODE = fill_flag_pkg::MODE_SINGLE_CONST,
    parameter fill_flag_pkg::count_t CONST_LEVEL = `FH_LEVEL_RESET,
    parameter fill_flag_pkg::count_t CONST_SET = `FH_SET_RESET,
    parameter fill_flag_pkg::count_t CONST_RELEASE = `FH_RELEASE_RESET
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic rd_en,
    fill_flag_if.dev link
);
    fill_flag_pkg::dev_state_t s_reg;
    fill_flag_pkg::dev_state_t s_next;
    fill_flag_pkg::level_mode_t mode_eff;
    logic wr_ok;
    logic rd_ok;

    // Primitive variants fall back to one constant level
    // dual only on memory
    function automatic fill_flag_pkg::level_mode_t pick_mode(input fill_flag_pkg::impl_t impl,
                                                           input fill_flag_pkg::level_mode_t m);
        if (impl == fill_flag_pkg::IMPL_PRIMITIVE) begin
            return fill_flag_pkg::MODE_SINGLE_CONST;
        end
        return m;
    endfunction

    // Level minus one, held at zero
    function automatic fill_flag_pkg::count_t dec_sat(input fill_flag_pkg::count_t v);
        if (v == '0) begin
            return '0;
        end
        return v - 5'h01;
    endfunction

    assign mode_eff = pick_mode(IMPL, MODE);
    assign wr_ok = link.wr_en && (s_reg.count != `FH_DEPTH);
    assign rd_ok = rd_en && (s_reg.count != '0);

    // Next state: occupancy, lagged outputs and flag machine
    always_comb begin
        s_next = s_reg;
        if (link.fifo_rst) begin
            s_next.count = '0;
            s_next.count_out = '0;
            s_next.full = 1'b0;
            s_next.flag = 1'b0;
            s_next.fstate = fill_flag_pkg::FS_LOW;
            s_next.lag = '0;
            case (mode_eff)
                fill_flag_pkg::MODE_SINGLE_PORT: begin
                    s_next.set_lvl = link.fill_high_level_in;
                    s_next.rel_lvl = link.fill_high_level_in;
                end
                fill_flag_pkg::MODE_DUAL_PORT: begin
                    s_next.set_lvl = link.fill_high_set_level_in;
                    s_next.rel_lvl = link.fill_high_release_level_in;
                end
                fill_flag_pkg::MODE_DUAL_CONST: begin
                    s_next.set_lvl = CONST_SET;
                    s_next.rel_lvl = CONST_RELEASE;
                end
                default: begin
                    s_next.set_lvl = CONST_LEVEL;
                    s_next.rel_lvl = (IMPL == fill_flag_pkg::IMPL_PRIMITIVE) ? dec_sat(CONST_LEVEL) : CONST_LEVEL;
                end
            endcase
        end else begin
            if (wr_ok && !rd_ok) begin
                s_next.count = s_reg.count + 5'h01;
            end else if (rd_ok && !wr_ok) begin
                s_next.count = s_reg.count - 5'h01;
            end
            s_next.full = (s_next.count == `FH_DEPTH);
            s_next.count_out = s_reg.count;
            case (s_reg.fstate)
                fill_flag_pkg::FS_LOW: begin
                    if (s_reg.count >= s_reg.set_lvl) begin
                        s_next.fstate = fill_flag_pkg::FS_HIGH;
                        s_next.flag = 1'b1;
                    end
                end
                fill_flag_pkg::FS_HIGH: begin
                    if (s_reg.count < s_reg.rel_lvl) begin
                        s_next.fstate = fill_flag_pkg::FS_DROP;
                        s_next.lag = '0;
                    end
                end
                fill_flag_pkg::FS_DROP: begin
                    if (s_reg.count >= s_reg.rel_lvl) begin
                        s_next.fstate = fill_flag_pkg::FS_HIGH;
                    end else if (s_reg.lag == '1) begin
                        s_next.fstate = fill_flag_pkg::FS_LOW;
                        s_next.flag = 1'b0;
                    end else begin
                        s_next.lag = s_reg.lag + 1'b1;
                    end
                end
                default: begin
                    s_next.fstate = fill_flag_pkg::FS_LOW;
                    s_next.flag = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '{count: '0, count_out: '0, full: 1'b0, flag: 1'b0, fstate: fill_flag_pkg::FS_LOW,
                       lag: '0, set_lvl: CONST_SET, rel_lvl: CONST_RELEASE};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.full = s_reg.full;
    assign link.fill_high_flag = s_reg.flag;
    assign link.wr_count = s_reg.count_out;
endmodule

// File: verilog/fill_high_user.sv
// Write-side user logic: AHB-Lite registers drive FIFO reset, writes and levels.
// Assumes a single AHB-Lite master and one slave on hclk.
`timescale 1ns/1ns
`include "fill_flag_regs.svh"

module fill_high_user (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    fill_flag_if.user link
);
    fill_flag_pkg::user_state_t s_reg;
    fill_flag_pkg::user_state_t s_next;
    logic take;

    assign take = hsel && hready && (htrans == `FH_HTRANS_NONSEQ);

    // Bus slave, register file and link drive
    always_comb begin
        s_next = s_reg;
        if (take) begin
            s_next.pend = 1'b1;
            s_next.pend_write = hwrite;
            s_next.pend_addr = haddr;
            s_next.hreadyout = 1'b0;
        end else if (s_reg.pend) begin
            s_next.pend = 1'b0;
            s_next.hreadyout = 1'b1;
            s_next.hrdata = 32'h0000_0000;
            if (s_reg.pend_write) begin
                if (s_reg.pend_addr == `FH_OFF_CTRL) begin
                    s_next.ctrl = hwdata[1:0];
                end else if (s_reg.pend_addr == `FH_OFF_LEVEL) begin
                    s_next.level = hwdata[`FH_CNT_W-1:0];
                end else if (s_reg.pend_addr == `FH_OFF_SET) begin
                    s_next.set_lvl = hwdata[`FH_CNT_W-1:0];
                end else if (s_reg.pend_addr == `FH_OFF_RELEASE) begin
                    s_next.rel_lvl = hwdata[`FH_CNT_W-1:0];
                end
            end else begin
                if (s_reg.pend_addr == `FH_OFF_CTRL) begin
                    s_next.hrdata[1:0] = s_reg.ctrl;
                end else if (s_reg.pend_addr == `FH_OFF_LEVEL) begin
                    s_next.hrdata[`FH_CNT_W-1:0] = s_reg.level;
                end else if (s_reg.pend_addr == `FH_OFF_SET) begin
                    s_next.hrdata[`FH_CNT_W-1:0] = s_reg.set_lvl;
                end else if (s_reg.pend_addr == `FH_OFF_RELEASE) begin
                    s_next.hrdata[`FH_CNT_W-1:0] = s_reg.rel_lvl;
                end else if (s_reg.pend_addr == `FH_OFF_STATUS) begin
                    s_next.hrdata[`FH_STAT_FLAG_BIT] = link.fill_high_flag;
                    s_next.hrdata[`FH_STAT_FULL_BIT] = link.full;
                    s_next.hrdata[`FH_STAT_CNT_LSB +: `FH_CNT_W] = link.wr_count;
                end
            end
        end
        // single level moves only in reset
        if (s_reg.ctrl[`FH_CTRL_RST_BIT]) begin
            s_next.level_out = s_reg.level;
            s_next.set_out = s_reg.set_lvl;
            s_next.rel_out = s_reg.rel_lvl;
        end
        // writes stop on full, not on flag
        s_next.wr_en = s_reg.ctrl[`FH_CTRL_PUSH_BIT] && !s_reg.ctrl[`FH_CTRL_RST_BIT] && !link.full
                       && !(s_reg.wr_en && link.wr_count == `FH_DEPTH - 5'h01);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '{ctrl: `FH_CTRL_RESET, level: `FH_LEVEL_RESET, set_lvl: `FH_SET_RESET,
                       rel_lvl: `FH_RELEASE_RESET, level_out: `FH_LEVEL_RESET, set_out: `FH_SET_RESET,
                       rel_out: `FH_RELEASE_RESET, wr_en: 1'b0, pend: 1'b0, pend_write: 1'b0,
                       pend_addr: 32'h0000_0000, hreadyout: 1'b1, hrdata: 32'h0000_0000};
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout = s_reg.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = s_reg.hrdata;
    assign link.fifo_rst = s_reg.ctrl[`FH_CTRL_RST_BIT];
    assign link.wr_en = s_reg.wr_en;
    assign link.fill_high_level_in = s_reg.level_out;
    assign link.fill_high_set_level_in = s_reg.set_out;
    assign link.fill_high_release_level_in = s_reg.rel_out;
endmodule
